// >>> include/tppwm_pkg.sv
package tppwm_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_HALF_PERIOD = 8'h00;
    localparam logic [7:0]  OFS_DEAD_TIME   = 8'h04;
    localparam logic [7:0]  OFS_MIN_PULSE   = 8'h08;
    localparam logic [7:0]  OFS_SYNC_WIDTH  = 8'h0C;
    localparam logic [7:0]  OFS_DUTY_A      = 8'h10;
    localparam logic [7:0]  OFS_DUTY_B      = 8'h14;
    localparam logic [7:0]  OFS_DUTY_C      = 8'h18;
    localparam logic [7:0]  OFS_SEGMENT     = 8'h1C;
    localparam logic [7:0]  OFS_MODE_CTRL   = 8'h20;
    localparam logic [7:0]  OFS_SYS_STATUS  = 8'h24;
    // field positions
    localparam int          MODE_DOUBLE_BIT = 6;
    localparam int          STAT_HALF_BIT   = 3;
    localparam int          STAT_RUN_BIT    = 0;
    // reset values
    localparam logic [7:0]  SYNC_WIDTH_RST  = 8'h27;
    localparam logic [15:0] HALF_PERIOD_RST = 16'h0000;
    localparam logic [9:0]  DEAD_TIME_RST   = 10'h000;
    localparam logic [8:0]  SEGMENT_RST     = 9'h000;
    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // counter direction
    typedef enum logic {
        TPPWM_UP   = 1'b0,
        TPPWM_DOWN = 1'b1
    } tppwm_dir_type;
endpackage

// >>> rtl/tppwm_timing.sv
`timescale 1ns/10ps
// Operation
// - every timing count advances once per clk period
// - half period register counts clocks in half a switching period
// - half period register is 16 bits, any value up to all ones
// - dead time inserted between complementary outputs of each pair
// - dead time equals register value times two clocks
// - dead time register is 10 bits wide
// - zero dead time register inserts no dead time
// - mode bit 6 selects single (0) or double (1) update
// - mode bit resets cleared, single update
// - single update gives one sync pulse per period at its start
// - sync rising edge loads timing and duty working copies
// - sync rising edge loads segment settings to output stage
// - double update adds midpoint sync pulse which also reloads
// - status bit 3 clear in first half, set in second half
// - sync pulse lasts width register plus one clocks
// - sync width register resets to 0x27
// - sync pulse is provided to the converter sequencer
// - sync pulse raises an interrupt request
// - counters stay stopped until period and all duties written
// - duty value sets high side on time per half period
module tppwm_timing
    import tppwm_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [5:0]         pwm_out,
    output logic [8:0]         output_segment_ctrl,
    output logic               period_sync_pulse,
    output logic               adc_sync,
    output logic               sync_irq
);
    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [15:0] half_period_count_r;
    logic [9:0]  dead_time_count_r;
    logic [15:0] min_pulse_count_r;
    logic [7:0]  sync_pulse_width_r;
    logic [15:0] duty_r [3];
    logic [8:0]  segment_r;
    logic [15:0] mode_control_r;
    logic [3:0]  written_r;
    // ------------------------------------------------------------
    // working copies and timing state
    // ------------------------------------------------------------
    logic [15:0]   wk_period_r;
    logic [9:0]    wk_dead_r;
    logic [15:0]   wk_minp_r;
    logic [7:0]    wk_swidth_r;
    logic [15:0]   wk_duty_r [3];
    logic [15:0]   cnt_r;
    tppwm_dir_type dir_r;
    logic          half_r;
    logic [7:0]    sync_cnt_r;
    logic          sync_r;
    logic          load_r;
    logic [5:0]    raw_r;
    logic [10:0]   dt_cnt_r [3];
    logic [5:0]    out_r;
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic          aw_hold_r;
    logic          w_hold_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0]   wdata_r;
    logic          bvalid_r;
    logic          rvalid_r;
    logic [31:0]   rdata_r;
    logic [1:0]    rresp_r;
    logic [1:0]    bresp_r;

    // address and data are taken in either order, then written together
    wire aw_take = s_axi_awvalid && !aw_hold_r && !bvalid_r;
    wire w_take  = s_axi_wvalid && !w_hold_r && !bvalid_r;
    wire do_wr   = aw_hold_r && w_hold_r && !bvalid_r;
    wire ar_take = s_axi_arvalid && !rvalid_r;
    wire [7:0] wa = 8'(awaddr_r);
    wire [7:0] ra = 8'(s_axi_araddr);
    wire wr_ok = (wa <= OFS_MODE_CTRL) && (wa[1:0] == 2'b00);
    wire rd_ok = (ra <= OFS_SYS_STATUS) && (ra[1:0] == 2'b00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // byte strobes are not sampled in the write cycle, wstrb held by master
    // is not guaranteed, so strobes are latched with data
    logic [3:0] wstrb_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            wstrb_r <= 4'h0;
        else if (w_take)
            wstrb_r <= s_axi_wstrb;
    end
    wire [15:0] wval = {wstrb_r[1] ? wdata_r[15:8] : 8'h00,
                        wstrb_r[0] ? wdata_r[7:0] : 8'h00};
    wire        wen  = do_wr && wr_ok && |wstrb_r[1:0];

    // register writes; the written mask arms the counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_period_count_r <= HALF_PERIOD_RST;
            dead_time_count_r   <= DEAD_TIME_RST;
            min_pulse_count_r   <= 16'h0000;
            sync_pulse_width_r  <= SYNC_WIDTH_RST;
            duty_r[0]           <= 16'h0000;
            duty_r[1]           <= 16'h0000;
            duty_r[2]           <= 16'h0000;
            segment_r           <= SEGMENT_RST;
            mode_control_r      <= 16'h0000;
            written_r           <= 4'h0;
        end else if (wen) begin
            unique case (wa)
                OFS_HALF_PERIOD: begin
                    half_period_count_r <= wval;
                    written_r[0]        <= 1'b1;
                end
                OFS_DEAD_TIME:  dead_time_count_r  <= wval[9:0];
                OFS_MIN_PULSE:  min_pulse_count_r  <= wval;
                OFS_SYNC_WIDTH: sync_pulse_width_r <= wval[7:0];
                OFS_DUTY_A: begin
                    duty_r[0]    <= wval;
                    written_r[1] <= 1'b1;
                end
                OFS_DUTY_B: begin
                    duty_r[1]    <= wval;
                    written_r[2] <= 1'b1;
                end
                OFS_DUTY_C: begin
                    duty_r[2]    <= wval;
                    written_r[3] <= 1'b1;
                end
                OFS_SEGMENT:    segment_r      <= wval[8:0];
                default:        mode_control_r <= wval;
            endcase
        end
    end

    wire dbl     = mode_control_r[MODE_DOUBLE_BIT];
    // counters run only once period and all three duties are written
    wire running = &written_r;

    // read mux
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (ra)
            OFS_HALF_PERIOD: rmux = {16'h0000, half_period_count_r};
            OFS_DEAD_TIME:   rmux = {22'h000000, dead_time_count_r};
            OFS_MIN_PULSE:   rmux = {16'h0000, min_pulse_count_r};
            OFS_SYNC_WIDTH:  rmux = {24'h000000, sync_pulse_width_r};
            OFS_DUTY_A:      rmux = {16'h0000, duty_r[0]};
            OFS_DUTY_B:      rmux = {16'h0000, duty_r[1]};
            OFS_DUTY_C:      rmux = {16'h0000, duty_r[2]};
            OFS_SEGMENT:     rmux = {23'h000000, segment_r};
            OFS_MODE_CTRL:   rmux = {16'h0000, mode_control_r};
            OFS_SYS_STATUS:  rmux = {28'h0000000, half_r, 2'b00, running};
            default:         rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rmux;
            rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // centre-aligned counter
    // ------------------------------------------------------------
    // up/down counter over half period
    wire at_top = (dir_r == TPPWM_UP) && (cnt_r >= wk_period_r - 16'h0001);
    // down leg ends at zero so both legs span the full half period
    wire at_bot = (dir_r == TPPWM_DOWN) && (cnt_r == 16'h0000);
    wire sync_ev = running && (!load_r || at_bot || (at_top && dbl));
    wire sync_end = (sync_cnt_r == 8'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_r <= 1'b0;
            cnt_r  <= 16'h0000;
            dir_r  <= TPPWM_UP;
            half_r <= 1'b0;
        end else if (!running) begin
            load_r <= 1'b0;
            cnt_r  <= 16'h0000;
            dir_r  <= TPPWM_UP;
            half_r <= 1'b0;
        end else begin
            load_r <= 1'b1;
            if (!load_r || at_bot) begin
                cnt_r  <= 16'h0000;
                dir_r  <= TPPWM_UP;
                half_r <= 1'b0;
            end else if (at_top) begin
                dir_r  <= TPPWM_DOWN;
                half_r <= 1'b1;
            end else if (dir_r == TPPWM_UP) begin
                cnt_r <= cnt_r + 16'h0001;
            end else begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end
    end

    // latch working copies on sync edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wk_period_r <= HALF_PERIOD_RST;
            wk_dead_r   <= DEAD_TIME_RST;
            wk_minp_r   <= 16'h0000;
            wk_swidth_r <= SYNC_WIDTH_RST;
            wk_duty_r[0] <= 16'h0000;
            wk_duty_r[1] <= 16'h0000;
            wk_duty_r[2] <= 16'h0000;
            output_segment_ctrl <= SEGMENT_RST;
        end else if (sync_ev) begin
            wk_period_r <= half_period_count_r;
            wk_dead_r   <= dead_time_count_r;
            wk_minp_r   <= min_pulse_count_r;
            wk_swidth_r <= sync_pulse_width_r;
            wk_duty_r[0] <= duty_r[0];
            wk_duty_r[1] <= duty_r[1];
            wk_duty_r[2] <= duty_r[2];
            output_segment_ctrl <= segment_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r     <= 1'b0;
            sync_cnt_r <= 8'h00;
        end else if (sync_ev) begin
            sync_r     <= 1'b1;
            sync_cnt_r <= sync_pulse_width_r;
        end else if (sync_r) begin
            sync_r     <= !sync_end;
            sync_cnt_r <= sync_end ? 8'h00 : sync_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_sync_pulse <= 1'b0;
            adc_sync          <= 1'b0;
            sync_irq          <= 1'b0;
        end else begin
            period_sync_pulse <= sync_r;
            adc_sync          <= sync_r;
            sync_irq          <= sync_ev;
        end
    end

    // ------------------------------------------------------------
    // per phase compare and dead time
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            // duty sets high side time in each half
            wire [15:0] lo_th = wk_period_r - wk_duty_r[g];
            wire        hi_raw = running && load_r && (cnt_r >= lo_th);
            wire [10:0] dt2     = {wk_dead_r, 1'b0};
            wire        dt_zero = (wk_dead_r == 10'h000);
            // gap ends on the edge at which the count reaches zero
            wire        dt_done = (dt_cnt_r[g] <= 11'h001);
            wire        dt_idle = (dt_cnt_r[g] == 11'h000);
            wire        settle  = (hi_raw == raw_r[g]) ? dt_done : dt_zero;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    raw_r[g]    <= 1'b0;
                    dt_cnt_r[g] <= 11'h000;
                end else if (hi_raw != raw_r[g]) begin
                    raw_r[g]    <= hi_raw;
                    dt_cnt_r[g] <= dt2;
                end else if (!dt_idle) begin
                    dt_cnt_r[g] <= dt_cnt_r[g] - 11'h001;
                end
            end
            // both off while dead time runs
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_r[2*g]   <= 1'b0;
                    out_r[2*g+1] <= 1'b0;
                end else begin
                    out_r[2*g]   <= hi_raw && settle;
                    out_r[2*g+1] <= running && load_r && !hi_raw
                                    && settle;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pwm_out <= 6'h00;
        else
            pwm_out <= out_r;
    end

    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ar_take;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset mode
    mode_reset_a: assert property (@(posedge clk) $rose(rst_n)
        |-> !mode_control_r[MODE_DOUBLE_BIT])
        else $error("mode bit not clear after reset");
    width_reset_a: assert property (@(posedge clk) $rose(rst_n)
        |-> sync_pulse_width_r == 8'h27)
        else $error("sync width reset wrong");
    idle_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        !running |=> !sync_r && cnt_r == 16'h0000)
        else $error("counter moved before arming");
    sync_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_ev |=> wk_period_r == $past(half_period_count_r))
        else $error("working period not loaded");
    seg_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_ev |=> output_segment_ctrl == $past(segment_r))
        else $error("segment not latched");
    half_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (at_top && running && load_r) |=> half_r)
        else $error("half bit not set at midpoint");
    sync_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_ev && sync_pulse_width_r == 8'h00) |=> sync_r ##1 !sync_r)
        else $error("one clock sync wrong");
    no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(out_r[0] && out_r[1]))
        else $error("pair overlap");
    irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        sync_ev |=> sync_irq)
        else $error("no interrupt on sync");
endmodule

// >>> sim/tppwm_drive_model.sv
`timescale 1ns/10ps
// gate drivers and converter sequencer on the far side of the timing block
module tppwm_drive_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  pwm_out,
    input  wire logic        adc_sync,
    output logic      [15:0] conv_count,
    output logic             overlap_seen
);
    logic adc_prev_r;

    // ------------------------------------------------------------
    // conversion starts and bridge shoot-through watch
    // ------------------------------------------------------------
    // conversion per sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_prev_r   <= 1'b0;
            conv_count   <= 16'h0000;
            overlap_seen <= 1'b0;
        end else begin
            adc_prev_r <= adc_sync;
            if (adc_sync && !adc_prev_r) conv_count <= conv_count + 16'h0001;
            if (|(pwm_out & (pwm_out >> 1) & 6'h15)) overlap_seen <= 1'b1;
        end
    end
endmodule

// >>> sim/tppwm_timing_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("mismatch at %0t got %h expected %h", $time, got, exp); \
        end \
    end
module tppwm_timing_tb
    import tppwm_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [5:0]  pwm_out;
    logic [8:0]  output_segment_ctrl;
    logic        period_sync_pulse;
    logic        adc_sync;
    logic        sync_irq;
    logic [15:0] conv_count;
    logic        overlap_seen;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [1:0]  wr_resp;
    logic        ps_prev, irq_prev, irq_ok;
    logic [1:0]  half;
    int          fail_count, total_checks, ncyc, rise_at, gap_last, rises;
    int          wacc, width_last, adc_bad, quiet, g, k;
    int          on_acc[6], on_last[6];
    int          duty[3] = '{10, 12, 15};

    // clock at 100 ns period
    always #50 clk = ~clk;

    tppwm_timing #(.AW(8)) u_tppwm_timing (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pwm_out(pwm_out),
        .output_segment_ctrl(output_segment_ctrl),
        .period_sync_pulse(period_sync_pulse), .adc_sync(adc_sync),
        .sync_irq(sync_irq)
    );

    tppwm_drive_model u_tppwm_drive_model (
        .clk(clk), .rst_n(rst_n), .pwm_out(pwm_out), .adc_sync(adc_sync),
        .conv_count(conv_count), .overlap_seen(overlap_seen)
    );

    // ------------------------------------------------------------
    // mid-cycle monitor: sync spacing, width, on-times per period
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (period_sync_pulse === 1'b1 && ps_prev !== 1'b1) begin
            gap_last = ncyc - rise_at;
            rise_at  = ncyc;
            on_last  = on_acc;
            on_acc   = '{default: 0};
            irq_ok   = irq_prev;
            wacc     = 0;
            rises++;
        end
        if (period_sync_pulse === 1'b1) wacc++;
        else if (ps_prev === 1'b1) width_last = wacc;
        for (int j = 0; j < 6; j++) if (pwm_out[j] === 1'b1) on_acc[j]++;
        if (adc_sync !== period_sync_pulse) adc_bad++;
        ps_prev  = period_sync_pulse;
        irq_prev = sync_irq;
        ncyc++;
    end

    // ------------------------------------------------------------
    // bus tasks and helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        $display("timeout at %0t", $time);
        conclude();
    endtask

    task automatic test_end(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic aw_t, w_t, b_t;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            aw_t    = s_axi_awvalid & s_axi_awready;
            w_t     = s_axi_wvalid & s_axi_wready;
            b_t     = s_axi_bvalid;
            wr_resp = s_axi_bresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask

    task automatic axi_read(input logic [7:0] a);
        int   n;
        logic ar_t, r_t;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ar_t    = s_axi_arvalid & s_axi_arready;
            r_t     = s_axi_rvalid;
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            @(posedge clk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask

    task automatic wait_syncs(input int cnt);
        int n;
        int goal;
        goal = rises + cnt;
        for (n = 0; n < 3000 && rises < goal; n++) begin
            @(negedge clk);
            #1;
        end
        if (rises < goal) hang();
    endtask

    // cycles from output a falling until output b rises
    task automatic edge_gap(input int a, input int b, output int gap);
        int   n;
        logic p;
        p   = 1'b0;
        gap = -1;
        for (n = 0; n < 500; n++) begin
            @(negedge clk);
            if (p === 1'b1 && pwm_out[a] === 1'b0) gap = 0;
            if (gap >= 0 && pwm_out[b] === 1'b1) break;
            if (gap >= 0) gap++;
            p = pwm_out[a];
        end
        if (n == 500) hang();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axi_read(OFS_SYNC_WIDTH);
        `CHK(rd_data, 32'h00000027)
        axi_read(OFS_MODE_CTRL);
        `CHK(rd_data[MODE_DOUBLE_BIT], 1'b0)
        axi_read(8'h28);
        `CHK(rd_resp, RESP_SLVERR)
        `CHK(rd_data, 32'h00000000)
        axi_write(8'h30, 32'h0000FFFF);
        `CHK(wr_resp, RESP_SLVERR)
        axi_write(OFS_HALF_PERIOD, 32'h0000FFFF);
        axi_read(OFS_HALF_PERIOD);
        `CHK(rd_data[15:0], 16'hFFFF)
        axi_write(OFS_DEAD_TIME, 32'h0000FFFF);
        axi_read(OFS_DEAD_TIME);
        `CHK(rd_data[9:0], 10'h3FF)
        test_end("registers");
        axi_write(OFS_HALF_PERIOD, 32'h00000014);
        axi_write(OFS_DEAD_TIME, 32'h00000002);
        axi_write(OFS_SYNC_WIDTH, 32'h00000003);
        axi_write(OFS_DUTY_A, 32'h0000000A);
        axi_write(OFS_DUTY_B, 32'h0000000C);
        quiet = 0;
        repeat (100) begin
            @(negedge clk);
            if (period_sync_pulse !== 1'b0 || pwm_out !== 6'h00) quiet++;
        end
        `CHK(quiet, 0)
        axi_write(OFS_DUTY_C, 32'h0000000F);
        wait_syncs(3);
        `CHK(gap_last, 40)
        `CHK(irq_ok, 1'b1)
        for (k = 0; k < 3; k++) begin
            `CHK(on_last[2*k], 2 * (duty[k] - 2))
            `CHK(on_last[2*k+1], 2 * (20 - duty[k] - 2))
        end
        repeat (8) @(negedge clk);
        `CHK(width_last, 4)
        `CHK(adc_bad, 0)
        `CHK(conv_count, rises[15:0])
        for (k = 0; k < 6; k++) begin
            edge_gap(k, k ^ 1, g);
            `CHK(g, 4)
        end
        `CHK(overlap_seen, 1'b0)
        test_end("single update");
        axi_write(OFS_DEAD_TIME, 32'h00000000);
        wait_syncs(3);
        `CHK(on_last[0], 20)
        edge_gap(0, 1, g);
        `CHK(g, 0)
        wait_syncs(1);
        axi_write(OFS_HALF_PERIOD, 32'h0000001E);
        axi_write(OFS_SEGMENT, 32'h000001A5);
        @(negedge clk);
        `CHK(output_segment_ctrl, 9'h000)
        wait_syncs(1);
        `CHK(gap_last, 40)
        `CHK(output_segment_ctrl, 9'h1A5)
        wait_syncs(1);
        `CHK(gap_last, 60)
        test_end("latching");
        axi_write(OFS_MODE_CTRL, 32'h00000040);
        axi_write(OFS_HALF_PERIOD, 32'h00000028);
        axi_read(OFS_MODE_CTRL);
        `CHK(rd_data[MODE_DOUBLE_BIT], 1'b1)
        wait_syncs(3);
        `CHK(gap_last, 40)
        for (k = 0; k < 2; k++) begin
            wait_syncs(1);
            axi_read(OFS_SYS_STATUS);
            half[k] = rd_data[STAT_HALF_BIT];
        end
        `CHK(half[0] ^ half[1], 1'b1)
        axi_write(OFS_SEGMENT, 32'h00000055);
        wait_syncs(2);
        `CHK(output_segment_ctrl, 9'h055)
        axi_write(OFS_SYNC_WIDTH, 32'h00000000);
        wait_syncs(2);
        repeat (4) @(negedge clk);
        `CHK(width_last, 1)
        test_end("double update");
        conclude();
    end
endmodule
